// ### logic/cmb_pkg.sv
// Purpose: shared constants for the controller memory bus block
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes: byte addresses are word aligned
package cmb_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00; // mode, busy, error
  localparam logic [7:0] OFS_ADDR = 8'h04; // external bus address
  localparam logic [7:0] OFS_WDATA = 8'h08; // byte to write
  localparam logic [7:0] OFS_CMD = 8'h0c; // start a bus cycle
  localparam logic [7:0] OFS_RDATA = 8'h10; // last byte read
  localparam logic [7:0] OFS_PORT = 8'h14; // select lines, boot oe
  localparam logic [7:0] OFS_ADC0 = 8'h20; // first analog channel
  localparam logic [7:0] OFS_ADC_END = 8'h40; // past last channel
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_MODE_BIT = 0; // 1 = bootstrap
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_ERR_BIT = 2; // sticky, cleared by a new command
  localparam int ST_NMI_BIT = 3; // synchronised interrupt input
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WR_BIT = 1;
  localparam int CMD_TGT_BIT = 2; // 0 flash, 1 sram
  localparam int PORT_SHARED_BIT = 0; // 1 = shared select low
  localparam int PORT_DEC_LSB = 1; // 3-bit decoder code
  localparam int PORT_BOOT_OE_BIT = 4; // 1 = flash oe low in boot
  localparam logic [2:0] DEC_IDLE = 3'h0; // decoder code: none
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int STROBE_NS = 150; // least strobe width
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int FLASH_BYTES = 524288; // program store size
  localparam int INT_RAM_BYTES = 3072; // on-chip ram, never external
  localparam int EEPROM_BYTES = 16384; // parameter store
  typedef enum logic {CMB_EXPANDED, CMB_BOOTSTRAP} cmb_mode_t;
  typedef enum logic [1:0] {CMB_IDLE, CMB_SETUP, CMB_STROBE,
    CMB_HOLD} cmb_state_t;
endpackage

// ### logic/cmb_top.sv
// Purpose: external memory bus, mode straps and analog readout
// Assumes: adc codes arrive from converter pins, 8 bits per channel
// Notes: one bus cycle at a time, started by a register write
//
// How it works
// - two modes only: expanded and bootstrap
// - expanded mode drives 16 address, 8 data lines
// - flash select, sram select, read/write line
// - eeprom and board selects via 3 decoder lines
// - one shared select for serial peripherals
// - shared select low around a serial transfer
// - mode_a pulled low at each instruction start in expanded mode
// - eight 8-bit analog channels readable by software
// - flash never written in expanded mode
// - bootstrap: flash oe from a port bit
// - flash holds 512 kilobytes of program
// - 16 kilobyte serial eeprom behind the decoder
// - sram access shown by its select going low
// - 3 kilobyte on-chip ram kept off the bus
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module cmb_top #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int ADC_CH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ADDR_W-1:0] ext_addr,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic [DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  output logic program_memory_select_n,
  output logic general_purpose_select_n,
  output logic access_direction_line, // 1 = read
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [2:0] decoder_lines,
  output logic shared_peripheral_select_n,
  input wire logic mode_a_instruction_marker_in,
  output logic mode_a_instruction_marker_out,
  output logic mode_a_instruction_marker_oe,
  input wire logic mode_b_standby_input,
  input wire logic nonmaskable_interrupt_input,
  input wire logic [ADC_CH*8-1:0] analog_input_channels
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYN_W = DATA_W + 3 + ADC_CH * 8;
  logic [SYN_W-1:0] syn1_reg; // first stage, read only by syn2
  logic [SYN_W-1:0] syn2_reg;
  always_ff @(posedge aclk) begin
    syn1_reg <= {analog_input_channels, nonmaskable_interrupt_input,
      mode_b_standby_input, mode_a_instruction_marker_in, ext_data_in};
    syn2_reg <= syn1_reg;
  end
  logic [DATA_W-1:0] data_s;
  logic mode_a_s, mode_b_s, nmi_s;
  logic [ADC_CH*8-1:0] adc_s;
  assign data_s = syn2_reg[DATA_W-1:0];
  assign mode_a_s = syn2_reg[DATA_W];
  assign mode_b_s = syn2_reg[DATA_W+1];
  assign nmi_s = syn2_reg[DATA_W+2]; // reported only
  assign adc_s = syn2_reg[SYN_W-1:DATA_W+3];

  // ----------------------------------------------------------------
  // mode strap, caught once after reset release
  // ----------------------------------------------------------------
  // the straps need the two sync stages to fill, so capture waits
  logic [1:0] strap_wait_reg;
  logic strap_done_reg;
  cmb_pkg::cmb_mode_t mode_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      mode_reg <= cmb_pkg::CMB_EXPANDED;
    end else if (!strap_done_reg) begin
      if (strap_wait_reg == 2'h3) begin
        strap_done_reg <= 1'b1;
        // both low means bootstrap; anything else runs expanded
        mode_reg <= (!mode_a_s && !mode_b_s) ? cmb_pkg::CMB_BOOTSTRAP
          : cmb_pkg::CMB_EXPANDED;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg; // lanes of the taken write, held with data
  logic aw_have_reg, w_have_reg;
  logic wr_fire;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic [4:0] port_reg; // shared select, decoder code, boot oe
  logic busy_reg, err_reg;
  logic cmd_go, cmd_wr, cmd_tgt;
  cmb_pkg::cmb_state_t state_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cmb_pkg::RESP_OKAY;
    end else begin
      // address and data are taken in either order
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        // the master may move wstrb once wready is seen, so keep a copy
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == cmb_pkg::OFS_ADDR ||
          aw_addr_reg == cmb_pkg::OFS_WDATA ||
          aw_addr_reg == cmb_pkg::OFS_CMD ||
          aw_addr_reg == cmb_pkg::OFS_PORT) ? cmb_pkg::RESP_OKAY
          : cmb_pkg::RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // register writes; lowest byte lane carries every field except address bits 15:8, which come on lane 1
  assign cmd_go = wr_fire && aw_addr_reg == cmb_pkg::OFS_CMD &&
    w_strb_reg[0] && w_data_reg[cmb_pkg::CMD_GO_BIT];
  assign cmd_wr = w_data_reg[cmb_pkg::CMD_WR_BIT];
  assign cmd_tgt = w_data_reg[cmb_pkg::CMD_TGT_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      port_reg <= 5'h00;
    end else if (wr_fire) begin
      if (aw_addr_reg == cmb_pkg::OFS_ADDR) begin
        if (w_strb_reg[0]) addr_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) addr_reg[15:8] <= w_data_reg[15:8];
      end else if (aw_addr_reg == cmb_pkg::OFS_WDATA) begin
        if (w_strb_reg[0]) wdata_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == cmb_pkg::OFS_PORT) begin
        // refused while a bus cycle runs so selects never overlap
        if (w_strb_reg[0] && !busy_reg) begin
          port_reg <= w_data_reg[4:0];
        end
      end
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cmb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cmb_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr[7:0] == cmb_pkg::OFS_STATUS) begin
        s_axi_rdata[cmb_pkg::ST_MODE_BIT] <= mode_reg;
        s_axi_rdata[cmb_pkg::ST_BUSY_BIT] <= busy_reg;
        s_axi_rdata[cmb_pkg::ST_ERR_BIT] <= err_reg;
        s_axi_rdata[cmb_pkg::ST_NMI_BIT] <= nmi_s;
      end else if (s_axi_araddr[7:0] == cmb_pkg::OFS_ADDR) begin
        s_axi_rdata[15:0] <= addr_reg;
      end else if (s_axi_araddr[7:0] == cmb_pkg::OFS_WDATA) begin
        s_axi_rdata[7:0] <= wdata_reg;
      end else if (s_axi_araddr[7:0] == cmb_pkg::OFS_RDATA) begin
        s_axi_rdata[7:0] <= rdata_reg;
      end else if (s_axi_araddr[7:0] == cmb_pkg::OFS_PORT) begin
        s_axi_rdata[4:0] <= port_reg;
      end else if (s_axi_araddr[7:0] >= cmb_pkg::OFS_ADC0 &&
          s_axi_araddr[7:0] < cmb_pkg::OFS_ADC_END) begin
        // unsigned 0..255 code per channel
        s_axi_rdata[7:0] <= adc_s[s_axi_araddr[4:2]*8 +: 8];
      end else begin
        s_axi_rresp <= cmb_pkg::RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // external bus cycle engine
  // ----------------------------------------------------------------
  // a command is refused (error set) for flash writes in expanded
  // mode, for on-chip ram addresses, or while port selects are low
  logic refuse;
  logic [7:0] strobe_cnt_reg;
  logic cyc_wr_reg, cyc_tgt_reg;
  assign refuse = (mode_reg == cmb_pkg::CMB_EXPANDED && cmd_wr &&
    !cmd_tgt) ||
    (32'(addr_reg) < cmb_pkg::INT_RAM_BYTES) ||
    port_reg[cmb_pkg::PORT_SHARED_BIT] ||
    port_reg[3:1] != cmb_pkg::DEC_IDLE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= cmb_pkg::CMB_IDLE;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      cyc_tgt_reg <= 1'b0;
      strobe_cnt_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      case (state_reg)
        cmb_pkg::CMB_IDLE: begin
          if (cmd_go && !busy_reg) begin
            err_reg <= refuse;
            if (!refuse) begin
              state_reg <= cmb_pkg::CMB_SETUP;
              busy_reg <= 1'b1;
              cyc_wr_reg <= cmd_wr;
              cyc_tgt_reg <= cmd_tgt;
            end
          end
        end
        cmb_pkg::CMB_SETUP: begin
          state_reg <= cmb_pkg::CMB_STROBE;
          strobe_cnt_reg <= 8'(cmb_pkg::STROBE_CYC + 2); // sync delay
        end
        cmb_pkg::CMB_STROBE: begin
          if (strobe_cnt_reg == 8'h01) begin
            state_reg <= cmb_pkg::CMB_HOLD;
            if (!cyc_wr_reg) rdata_reg <= data_s;
          end
          strobe_cnt_reg <= strobe_cnt_reg - 8'h01;
        end
        default: begin
          state_reg <= cmb_pkg::CMB_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // pin drivers, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr <= '0;
      ext_data_out <= '0;
      ext_data_oe <= 1'b0;
      program_memory_select_n <= 1'b1;
      general_purpose_select_n <= 1'b1;
      access_direction_line <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      decoder_lines <= cmb_pkg::DEC_IDLE;
      shared_peripheral_select_n <= 1'b1;
      mode_a_instruction_marker_out <= 1'b0;
      mode_a_instruction_marker_oe <= 1'b0;
    end else begin
      // address, data and direction change only while idle
      if (state_reg == cmb_pkg::CMB_IDLE && cmd_go && !refuse) begin
        ext_addr <= addr_reg[ADDR_W-1:0];
        ext_data_out <= wdata_reg[DATA_W-1:0];
        access_direction_line <= !cmd_wr;
      end
      ext_data_oe <= cyc_wr_reg && (state_reg == cmb_pkg::CMB_SETUP ||
        state_reg == cmb_pkg::CMB_STROBE);
      program_memory_select_n <= !(!cyc_tgt_reg &&
        (state_reg == cmb_pkg::CMB_SETUP ||
        state_reg == cmb_pkg::CMB_STROBE));
      general_purpose_select_n <= !(cyc_tgt_reg &&
        (state_reg == cmb_pkg::CMB_SETUP ||
        state_reg == cmb_pkg::CMB_STROBE));
      flash_we_n <= !(cyc_wr_reg && !cyc_tgt_reg &&
        state_reg == cmb_pkg::CMB_SETUP) &&
        !(cyc_wr_reg && !cyc_tgt_reg && state_reg == cmb_pkg::CMB_STROBE
        && strobe_cnt_reg != 8'h01);
      if (mode_reg == cmb_pkg::CMB_BOOTSTRAP) begin
        flash_oe_n <= !port_reg[cmb_pkg::PORT_BOOT_OE_BIT];
      end else begin
        flash_oe_n <= !(!cyc_wr_reg && !cyc_tgt_reg &&
          state_reg == cmb_pkg::CMB_STROBE);
      end
      // eeprom and board selects leave through the decoder code
      decoder_lines <= port_reg[3:1];
      shared_peripheral_select_n <=
        !port_reg[cmb_pkg::PORT_SHARED_BIT];
      // marker pulls low for one cycle at each new instruction in expanded mode
      mode_a_instruction_marker_oe <= mode_reg == cmb_pkg::CMB_EXPANDED
        && state_reg == cmb_pkg::CMB_IDLE && cmd_go && !refuse;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    state_reg == cmb_pkg::CMB_IDLE && cmd_go && !refuse;
  endsequence
  sequence s_prog_cycle;
    ##2 !program_memory_select_n [*2];
  endsequence
  chk_one_select: assert property (
    $countones({!program_memory_select_n, !general_purpose_select_n,
    !shared_peripheral_select_n, decoder_lines != cmb_pkg::DEC_IDLE})
    <= 1) else $error("two selects asserted");
  chk_dir_stable: assert property (
    (!program_memory_select_n || !general_purpose_select_n) &&
    $past(!program_memory_select_n || !general_purpose_select_n)
    |-> $stable(access_direction_line))
    else $error("direction moved inside a cycle");
  chk_no_flash_wr: assert property (
    mode_reg == cmb_pkg::CMB_EXPANDED |-> flash_we_n)
    else $error("flash write strobe in expanded mode");
  chk_marker_pulse: assert property (
    (s_start and (mode_reg == cmb_pkg::CMB_EXPANDED)) |=>
    mode_a_instruction_marker_oe ##1 !mode_a_instruction_marker_oe)
    else $error("marker pulse wrong");
  chk_flash_cycle: assert property (
    (s_start and (!cmd_wr && !cmd_tgt)) |-> s_prog_cycle)
    else $error("flash select missing");
  chk_sram_select: assert property (
    (s_start and cmd_tgt) |=> ##1 !general_purpose_select_n)
    else $error("sram select missing");
  chk_boot_oe: assert property (
    mode_reg == cmb_pkg::CMB_BOOTSTRAP |=>
    flash_oe_n == !$past(port_reg[cmb_pkg::PORT_BOOT_OE_BIT]))
    else $error("boot oe not from port bit");
  chk_shared_sel: assert property (
    $rose(port_reg[cmb_pkg::PORT_SHARED_BIT]) |=>
    !shared_peripheral_select_n) else $error("shared select late");
  chk_refuse_ram: assert property (
    !busy_reg && cmd_go && 32'(addr_reg) < cmb_pkg::INT_RAM_BYTES |=>
    program_memory_select_n && general_purpose_select_n [*2])
    else $error("on-chip ram address put on bus");
  chk_cycle_ends: assert property (
    s_start |-> ##[4:12] state_reg == cmb_pkg::CMB_IDLE)
    else $error("bus cycle did not end");
endmodule

// ### bench/cmb_mem_model.sv
// Purpose: far-side flash and sram seen by the memory bus block
// Assumes: flash content is a fixed pattern of the low address byte
// Notes: undriven data lines show the inverse of the last value
`timescale 1ns/10ps
module cmb_mem_model (
  input wire logic aclk,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic program_memory_select_n,
  input wire logic general_purpose_select_n,
  input wire logic access_direction_line,
  input wire logic flash_oe_n,
  output logic [7:0] ext_data_in
);
  logic [7:0] sram_mem [0:65535]; // sram image, one byte per address
  logic [7:0] last_reg = 8'h00; // last byte a memory drove
  logic drive; // some memory drives the data lines
  logic [7:0] drive_val;
  // ----------------------------------------------------------------
  // read path: only a selected, enabled memory drives
  // ----------------------------------------------------------------
  always @* begin
    drive = 1'b0;
    drive_val = last_reg;
    if (!general_purpose_select_n && access_direction_line) begin
      drive = 1'b1;
      drive_val = sram_mem[ext_addr];
    end else if (!program_memory_select_n && !flash_oe_n) begin
      drive = 1'b1;
      drive_val = ext_addr[7:0] ^ 8'h5a;
    end
  end
  // released lines do not keep a stale byte the block could mistake
  assign ext_data_in = drive ? drive_val : ~last_reg;
  // ----------------------------------------------------------------
  // sram write and line history; flash ignores writes here
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!general_purpose_select_n && !access_direction_line && ext_data_oe)
      sram_mem[ext_addr] <= ext_data_out;
    if (drive)
      last_reg <= drive_val;
  end
endmodule

// ### bench/controller_memory_bus_and_mode_select_tb.sv
// Purpose: self-checking bench for the controller memory bus block
// Assumes: registers reached through axi4-lite at 20 MHz
// Notes: mode straps stay high except during the bootstrap reset
`timescale 1ns/10ps
module controller_memory_bus_and_mode_select_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] ext_addr;
  logic [7:0] ext_data_in, ext_data_out;
  logic ext_data_oe, prog_n, gp_n, dir, foe_n, fwe_n, shared_n;
  logic mk_out, mk_oe, mode_a_pin;
  logic [2:0] dec;
  logic strap_a = 1'b1, strap_b = 1'b1, nmi = 1'b1; // high in normal run
  logic [63:0] adc = '0;
  int n_errors = 0, check_count = 0, we_count = 0, mk_count = 0;
  // open-drain marker pin with external pull-up on the strap level
  assign mode_a_pin = mk_oe ? 1'b0 : strap_a;
  initial forever #25 aclk = ~aclk;
  cmb_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_addr(ext_addr),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .program_memory_select_n(prog_n),
    .general_purpose_select_n(gp_n), .access_direction_line(dir),
    .flash_oe_n(foe_n), .flash_we_n(fwe_n), .decoder_lines(dec),
    .shared_peripheral_select_n(shared_n),
    .mode_a_instruction_marker_in(mode_a_pin),
    .mode_a_instruction_marker_out(mk_out),
    .mode_a_instruction_marker_oe(mk_oe),
    .mode_b_standby_input(strap_b),
    .nonmaskable_interrupt_input(nmi), .analog_input_channels(adc));
  cmb_mem_model mem (.aclk(aclk), .ext_addr(ext_addr),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .program_memory_select_n(prog_n), .general_purpose_select_n(gp_n),
    .access_direction_line(dir), .flash_oe_n(foe_n),
    .ext_data_in(ext_data_in));
  // counts cycles with the flash write strobe low, and instruction marker pulses
  always @(posedge aclk) begin
    if (!fwe_n) we_count++;
    if (mk_oe) mk_count++;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] adc_code(input int i);
    return (i == 7) ? 8'hff : 8'(i * 36); // both ends of the range
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // offers address and data together, releases each when taken
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 100);
    s_axi_bready <= 1'b0;
    if (t >= 100) n_errors++;
    check(s_axi_bresp, cmb_pkg::RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 100) n_errors++;
  endtask
  // one external cycle: cmd is {target, write, go}; waits on busy
  task automatic bus_cycle(input logic [15:0] a, input logic [7:0] d,
    input logic [2:0] cmd, output logic [31:0] st);
    logic [1:0] r;
    int t;
    t = 0;
    reg_wr(cmb_pkg::OFS_ADDR, {16'h0, a});
    reg_wr(cmb_pkg::OFS_WDATA, {24'h0, d});
    reg_wr(cmb_pkg::OFS_CMD, {29'h0, cmd});
    do begin
      axi_rd(cmb_pkg::OFS_STATUS, st, r);
      t++;
    end while (st[cmb_pkg::ST_BUSY_BIT] !== 1'b0 && t < 50);
    if (t >= 50) n_errors++;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sram_flash();
    logic [31:0] st, d;
    logic [1:0] r;
    int mk0, we0;
    check({prog_n, gp_n, shared_n, dec}, 6'h38);
    axi_rd(cmb_pkg::OFS_STATUS, d, r);
    check(d, 32'h8);
    bus_cycle(16'hffff, 8'ha5, 3'h7, st);
    bus_cycle(16'hffff, 8'h00, 3'h5, st);
    axi_rd(cmb_pkg::OFS_RDATA, d, r);
    check(d, 32'ha5);
    check(ext_addr, 16'hffff);
    mk0 = mk_count;
    bus_cycle(16'h0c00, 8'h00, 3'h1, st);
    axi_rd(cmb_pkg::OFS_RDATA, d, r);
    check(d, 32'h5a);
    check(mk_count - mk0, 1);
    bus_cycle(16'h0bff, 8'h00, 3'h5, st);
    check(st[cmb_pkg::ST_ERR_BIT], 1'b1);
    we0 = we_count;
    bus_cycle(16'h2000, 8'h11, 3'h3, st);
    check(st[cmb_pkg::ST_ERR_BIT], 1'b1);
    check(we_count - we0, 0);
    $display("test sram_flash done");
  endtask
  task automatic t_port_adc();
    logic [31:0] st, d;
    logic [1:0] r;
    reg_wr(cmb_pkg::OFS_PORT, 32'h1);
    @(posedge aclk); // pins follow the register one edge later
    check(shared_n, 1'b0);
    bus_cycle(16'h1000, 8'h00, 3'h5, st);
    check(st[cmb_pkg::ST_ERR_BIT], 1'b1);
    reg_wr(cmb_pkg::OFS_PORT, 32'h0);
    @(posedge aclk);
    check(shared_n, 1'b1);
    for (int c = 1; c < 8; c++) begin
      reg_wr(cmb_pkg::OFS_PORT, 32'(c << 1));
      @(posedge aclk);
      check(dec, c[2:0]);
    end
    bus_cycle(16'h1000, 8'h00, 3'h5, st);
    check({st[cmb_pkg::ST_ERR_BIT], gp_n}, 2'h3);
    reg_wr(cmb_pkg::OFS_PORT, 32'h0);
    for (int i = 0; i < 8; i++) begin
      axi_rd(8'(cmb_pkg::OFS_ADC0 + 4 * i), d, r);
      check(d, {24'h0, adc_code(i)});
    end
    axi_rd(cmb_pkg::OFS_ADC_END, d, r);
    check(r, cmb_pkg::RESP_DECERR);
    $display("test port_adc done");
  endtask
  task automatic t_boot();
    logic [31:0] st, d;
    logic [1:0] r;
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_a <= 1'b0;
    strap_b <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    strap_a <= 1'b1;
    strap_b <= 1'b1;
    axi_rd(cmb_pkg::OFS_STATUS, d, r);
    check(d[cmb_pkg::ST_MODE_BIT], 1'b1);
    reg_wr(cmb_pkg::OFS_PORT, 32'h10);
    @(posedge aclk);
    check(foe_n, 1'b0);
    bus_cycle(16'h0d21, 8'h00, 3'h1, st);
    axi_rd(cmb_pkg::OFS_RDATA, d, r);
    check(d, 32'h7b);
    reg_wr(cmb_pkg::OFS_PORT, 32'h0);
    @(posedge aclk);
    check(foe_n, 1'b1);
    $display("test boot done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) adc[i*8 +: 8] = adc_code(i);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk); // straps sampled after release
    t_sram_flash();
    t_port_adc();
    t_boot();
    stop_test();
  end
  // about seventy times the expected run length
  initial begin
    #1_000_000;
    n_errors++;
    stop_test();
  end
endmodule
